/* src/rfrx_consts.vh */
`ifndef RFRX_CONSTS_VH
`define RFRX_CONSTS_VH

// Register offsets on the host register port
`define RFRX_OFS_SOFD 8'h34
`define RFRX_OFS_RECEIVE_CONTROL 8'h35
`define RFRX_OFS_DEAD 8'h36
`define RFRX_OFS_THRESH 8'h37
`define RFRX_OFS_INCFG 8'h38

// Frame start detect register fields
`define RFRX_SOF_EN_BIT 5
`define RFRX_SOF_FLAG_BIT 4
`define RFRX_SUBCARRIER_IRQ_ENABLE_BIT 2
`define RFRX_SUBC_FLAG_BIT 1
`define RFRX_SUBC_LIVE_BIT 0

// Receive control fields
`define RFRX_ALLOW_BIT 7
`define RFRX_MULTI_BIT 6
`define RFRX_SUPP_BIT 3
`define RFRX_BAUD_MSB 2
`define RFRX_BAUD_LSB 0
`define RFRX_BAUD_26K 3'h2
`define RFRX_BAUD_52K 3'h3

// Dead time fields
`define RFRX_DT_UNIT_BIT 7
`define RFRX_DT_CNT_MSB 6

// Input config fields
`define RFRX_SINGLE_BIT 7
`define RFRX_ADC_BIT 6
`define RFRX_SIGSEL_MSB 5
`define RFRX_SIGSEL_LSB 4
`define RFRX_COLL_MSB 1
`define RFRX_COLL_OFF 2'h3

// Writable bit masks and reset values
`define RFRX_SOFD_WMASK 8'h24
`define RFRX_RECEIVE_CONTROL_WMASK 8'hcf
`define RFRX_INCFG_WMASK 8'hf3
`define RFRX_REG_RESET 8'h00

// Frame suppression byte limit
`define RFRX_SUPP_BYTES 2'h3

// Dead time carrier unit: 16 carrier periods, rounded up to clk cycles
`define RFRX_CLK_KHZ 40000
`define RFRX_CARRIER_KHZ 13560
`define RFRX_DT_CARRIER_PERIODS 16
// Sized to the unit counter so the unit select drops no bits
`define RFRX_DT_CARRIER_CYC 12'h030

`endif

/* src/rfrx_config_regs.v */
// Operation
// - Frame start enable raises frame start interrupt
// - Sticky frame start flag, software clears
// - Subcarrier enable raises same interrupt
// - Sticky subcarrier flag, software clears
// - Live subcarrier bit, read only
// - Partial byte allowed into FIFO
// - Multi frame keeps receiver running
// - Error byte appended after each stream in multi frame mode
// - Early error discards bytes, resets FIFO
// - Collision counts as reception error
// - Short frames, suppression cases: no completion interrupt
// - Baud field: 2h 26k, 3h 52k
// - Dead time unit: carrier or half bit
// - Dead time count ignores input after send
// - Decoder minimum level field
// - Phase detector minimum level field
// - Single input mode select bit
// - Converter mode: normal or card detection
// - Signal source select field
// - Collision level field, code 3 disables
// - Half bit unit from transmit bit rate
`timescale 1ns/1ps
`include "rfrx_consts.vh"

module rfrx_config_regs (
  input wire clk,
  input wire rst_n,
  // Host register port
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  output reg regRvalid,
  // Receiver events
  input wire txEnd,
  input wire sofDetect,
  input wire subcarrierLive,
  input wire collisionDetect,
  input wire rxError,
  input wire [7:0] errorRegValue,
  input wire frameEnd,
  input wire crcEnable,
  input wire [11:0] dataBitHalfPeriod,
  // Received bytes in
  input wire byteValid,
  input wire [7:0] byteData,
  input wire bytePartial,
  output wire byteReady,
  // Bytes out to the FIFO
  output wire fifoValid,
  output wire [7:0] fifoData,
  input wire fifoReady,
  output reg fifoReset,
  // Status and control outputs
  output wire frameStartInterrupt,
  output reg rxCompleteIrq,
  output reg rxStop,
  output wire rxIgnore,
  output wire [1:0] baudSelect,
  output wire baudValid,
  output wire [3:0] decoderMinLevel,
  output wire [3:0] phaseDetectorMinLevel,
  output wire singleInputMode,
  output wire lowPowerCardDetection,
  output wire [1:0] signalSourceSelect,
  output wire [1:0] collisionLevel,
  output wire collisionEnable
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [7:0] sofCtrl_r; // Enable bits of frame start register
  reg sofFlag_r; // Sticky frame start flag
  reg subcFlag_r; // Sticky subcarrier flag
  reg [7:0] receive_control_r; // Receive control
  reg [7:0] deadTime_r; // Dead time setting
  reg [7:0] thresh_r; // Threshold levels
  reg [7:0] inCfg_r; // Receiver input config
  reg [6:0] deadLeft_r; // Dead time units still to run
  reg [11:0] deadSub_r; // Cycle count inside one unit
  reg inFrame_r; // A frame has started
  reg [1:0] byteCnt_r; // Bytes in frame, saturates at three
  reg suppErr_r; // Frame hit a suppression error
  reg errPend_r; // Error byte waiting for buffer room
  reg [7:0] errByte_r; // Captured error byte
  reg [7:0] buf0_r; // Buffer head entry
  reg [7:0] buf1_r; // Buffer second entry
  reg [1:0] bufCnt_r; // Buffer fill level
  wire [7:0] sofRead; // Composed frame start register
  wire deadActive; // Inside dead time
  wire [11:0] deadUnit; // Cycles per dead time unit
  wire collCounted; // Collision taken as error
  wire anyErr; // Error in frame
  wire earlyErr; // Suppression error in first bytes
  wire dropPartial; // Partial byte refused
  wire inByte; // Byte accepted from receiver
  wire pushByte; // Byte placed in buffer
  wire pushErr; // Error byte placed in buffer
  wire push; // Any write into buffer
  wire pop; // Buffer entry taken by FIFO
  wire [7:0] pushData; // Data written into buffer
  wire bufFull; // Both entries used
  wire shortFrame; // Frame ended before three bytes
  wire sofEv; // Gated frame start event
  wire [7:0] rdNxt; // Read data for addressed register

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when a write strobe hits the given offset
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    input strobe;
    begin
      hit = strobe && (addr == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs
  assign baudSelect = receive_control_r[1:0];
  assign baudValid = (receive_control_r[`RFRX_BAUD_MSB:`RFRX_BAUD_LSB] ==
    `RFRX_BAUD_26K) || (receive_control_r[`RFRX_BAUD_MSB:`RFRX_BAUD_LSB] ==
    `RFRX_BAUD_52K);
  assign decoderMinLevel = thresh_r[7:4];
  assign phaseDetectorMinLevel = thresh_r[3:0];
  assign singleInputMode = inCfg_r[`RFRX_SINGLE_BIT];
  assign lowPowerCardDetection = inCfg_r[`RFRX_ADC_BIT];
  assign signalSourceSelect =
    inCfg_r[`RFRX_SIGSEL_MSB:`RFRX_SIGSEL_LSB];
  assign collisionLevel = inCfg_r[`RFRX_COLL_MSB:0];
  assign collisionEnable = (collisionLevel != `RFRX_COLL_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Dead time after sending
  // Unit is carrier based or half a data bit of the transmit rate
  assign deadUnit = deadTime_r[`RFRX_DT_UNIT_BIT] ? dataBitHalfPeriod :
    `RFRX_DT_CARRIER_CYC;
  assign deadActive = (deadLeft_r != 7'h00);
  assign rxIgnore = deadActive;

  // Count units down after each end of transmission
  always @(posedge clk) begin
    if (!rst_n) begin
      deadLeft_r <= 7'h00;
      deadSub_r <= 12'h000;
    end else if (txEnd) begin
      // Restart the window
      deadLeft_r <= deadTime_r[`RFRX_DT_CNT_MSB:0];
      deadSub_r <= 12'h000;
    end else if (deadActive) begin
      // Step through one unit at a time
      if (deadSub_r + 12'h001 >= deadUnit) begin
        deadSub_r <= 12'h000;
        deadLeft_r <= deadLeft_r - 7'h01;
      end else begin
        deadSub_r <= deadSub_r + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame start and subcarrier flags
  assign sofEv = sofDetect && !deadActive;
  assign sofRead = {2'b00, sofCtrl_r[`RFRX_SOF_EN_BIT], sofFlag_r, 1'b0,
    sofCtrl_r[`RFRX_SUBCARRIER_IRQ_ENABLE_BIT], subcFlag_r,
    subcarrierLive};
  assign frameStartInterrupt =
    (sofCtrl_r[`RFRX_SOF_EN_BIT] && sofFlag_r) ||
    (sofCtrl_r[`RFRX_SUBCARRIER_IRQ_ENABLE_BIT] && subcFlag_r);

  // Sticky flags: a new event wins over a software clear
  always @(posedge clk) begin
    if (!rst_n) begin
      sofFlag_r <= 1'b0;
      subcFlag_r <= 1'b0;
    end else begin
      if (sofEv) begin
        sofFlag_r <= 1'b1;
      end else if (hit(regAddr, `RFRX_OFS_SOFD, regWrite) &&
        !regWdata[`RFRX_SOF_FLAG_BIT]) begin
        sofFlag_r <= 1'b0;
      end
      if (subcarrierLive && !deadActive) begin
        subcFlag_r <= 1'b1;
      end else if (hit(regAddr, `RFRX_OFS_SOFD, regWrite) &&
        !regWdata[`RFRX_SUBC_FLAG_BIT]) begin
        subcFlag_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clk) begin
    if (!rst_n) begin
      sofCtrl_r <= `RFRX_REG_RESET;
      receive_control_r <= `RFRX_REG_RESET;
      deadTime_r <= `RFRX_REG_RESET;
      thresh_r <= `RFRX_REG_RESET;
      inCfg_r <= `RFRX_REG_RESET;
    end else begin
      if (hit(regAddr, `RFRX_OFS_SOFD, regWrite)) begin
        sofCtrl_r <= regWdata & `RFRX_SOFD_WMASK;
      end
      if (hit(regAddr, `RFRX_OFS_RECEIVE_CONTROL, regWrite)) begin
        receive_control_r <= regWdata & `RFRX_RECEIVE_CONTROL_WMASK;
      end
      if (hit(regAddr, `RFRX_OFS_DEAD, regWrite)) begin
        deadTime_r <= regWdata;
      end
      if (hit(regAddr, `RFRX_OFS_THRESH, regWrite)) begin
        thresh_r <= regWdata;
      end
      if (hit(regAddr, `RFRX_OFS_INCFG, regWrite)) begin
        inCfg_r <= regWdata & `RFRX_INCFG_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe
  assign rdNxt = (regAddr == `RFRX_OFS_SOFD) ? sofRead :
    (regAddr == `RFRX_OFS_RECEIVE_CONTROL) ? receive_control_r :
    (regAddr == `RFRX_OFS_DEAD) ? deadTime_r :
    (regAddr == `RFRX_OFS_THRESH) ? thresh_r :
    (regAddr == `RFRX_OFS_INCFG) ? inCfg_r : 8'h00;

  always @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= rdNxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame tracking and suppression
  assign collCounted = collisionDetect && collisionEnable;
  assign anyErr = (rxError || collCounted) && !deadActive;
  assign earlyErr = receive_control_r[`RFRX_SUPP_BIT] && inFrame_r && anyErr &&
    (byteCnt_r < `RFRX_SUPP_BYTES);
  assign shortFrame = receive_control_r[`RFRX_SUPP_BIT] && inFrame_r &&
    (byteCnt_r < `RFRX_SUPP_BYTES);

  // Byte count, error marks, stop and completion pulses
  always @(posedge clk) begin
    if (!rst_n) begin
      inFrame_r <= 1'b0;
      byteCnt_r <= 2'h0;
      suppErr_r <= 1'b0;
      fifoReset <= 1'b0;
      rxCompleteIrq <= 1'b0;
      rxStop <= 1'b0;
    end else begin
      fifoReset <= earlyErr;
      rxCompleteIrq <= 1'b0;
      rxStop <= 1'b0;
      if (sofEv) begin
        // New frame starts a fresh count
        inFrame_r <= 1'b1;
        byteCnt_r <= 2'h0;
        suppErr_r <= 1'b0;
      end else if (frameEnd) begin
        inFrame_r <= 1'b0;
        rxCompleteIrq <= !(suppErr_r || earlyErr || shortFrame);
        rxStop <= !receive_control_r[`RFRX_MULTI_BIT];
      end else begin
        if (earlyErr) begin
          // Discarded bytes restart the count
          suppErr_r <= 1'b1;
          byteCnt_r <= 2'h0;
        end else if (inByte && byteCnt_r != `RFRX_SUPP_BYTES) begin
          byteCnt_r <= byteCnt_r + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte path into the two-entry buffer
  assign bufFull = (bufCnt_r == 2'h2);
  assign dropPartial = bytePartial && crcEnable &&
    !receive_control_r[`RFRX_ALLOW_BIT];
  assign byteReady = !bufFull && !errPend_r;
  assign inByte = byteValid && byteReady && !deadActive;
  assign pushByte = inByte && !dropPartial;
  assign pushErr = errPend_r && !bufFull;
  assign push = pushByte || pushErr;
  assign pushData = errPend_r ? errByte_r : byteData;
  assign fifoValid = (bufCnt_r != 2'h0);
  assign fifoData = buf0_r;
  assign pop = fifoValid && fifoReady;

  // Capture the error byte at the end of each stream when multi frame is set
  always @(posedge clk) begin
    if (!rst_n) begin
      errPend_r <= 1'b0;
      errByte_r <= 8'h00;
    end else if (frameEnd && receive_control_r[`RFRX_MULTI_BIT]) begin
      errPend_r <= 1'b1;
      errByte_r <= errorRegValue;
    end else if (pushErr) begin
      errPend_r <= 1'b0;
    end
  end

  // Buffer: flushed on suppression, else push and pop freely
  always @(posedge clk) begin
    if (!rst_n) begin
      bufCnt_r <= 2'h0;
      buf0_r <= 8'h00;
      buf1_r <= 8'h00;
    end else if (earlyErr) begin
      bufCnt_r <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          // Fill next free entry
          if (bufCnt_r == 2'h0) begin
            buf0_r <= pushData;
          end else begin
            buf1_r <= pushData;
          end
          bufCnt_r <= bufCnt_r + 2'h1;
        end
        2'b01: begin
          // Shift second entry forward
          buf0_r <= buf1_r;
          bufCnt_r <= bufCnt_r - 2'h1;
        end
        2'b11: begin
          // Level unchanged
          if (bufCnt_r == 2'h1) begin
            buf0_r <= pushData;
          end else begin
            buf0_r <= buf1_r;
            buf1_r <= pushData;
          end
        end
        default: begin
          bufCnt_r <= bufCnt_r;
        end
      endcase
    end
  end

endmodule // rfrx_config_regs

/* testbench/rfrx_config_regs_sva.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module rfrx_regs_sva (
  input wire clk,
  input wire rst_n,
  input wire regRead,
  input wire regRvalid,
  input wire txEnd,
  input wire rxError,
  input wire collisionDetect,
  input wire frameEnd,
  input wire fifoReady,
  input wire fifoValid,
  input wire [7:0] fifoData,
  input wire fifoReset,
  input wire rxCompleteIrq,
  input wire rxStop,
  input wire rxIgnore,
  input wire [1:0] baudSelect,
  input wire baudValid,
  input wire [1:0] collisionLevel,
  input wire collisionEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Head word waiting on a stalled FIFO
  sequence s_stall;
    fifoValid && !fifoReady;
  endsequence
  // Head word still there, unchanged
  sequence s_kept;
    fifoValid && $stable(fifoData);
  endsequence
  a_read_answer: assert property (regRead |=> regRvalid)
    else $error("read without answer");
  a_read_quiet: assert property (!regRead |=> !regRvalid)
    else $error("answer without read");
  a_done_cause: assert property (rxCompleteIrq |-> $past(frameEnd))
    else $error("completion without frame end");
  a_stop_cause: assert property (rxStop |-> $past(frameEnd))
    else $error("stop without frame end");
  a_flush_cause: assert property (
    fifoReset |-> $past(rxError || collisionDetect))
    else $error("flush without error");
  a_ignore_start: assert property (!rxIgnore && !txEnd |=> !rxIgnore)
    else $error("dead time without send end");
  a_head_hold: assert property (s_stall |=> fifoReset or s_kept)
    else $error("stalled word lost");
  a_baud_code: assert property (baudValid |-> baudSelect[1])
    else $error("baud valid on reserved code");
  a_coll_off: assert property (
    collisionEnable == (collisionLevel != 2'h3))
    else $error("collision enable wrong");
endmodule // rfrx_regs_sva
bind rfrx_config_regs rfrx_regs_sva i_rfrx_regs_sva (.clk, .rst_n,
  .regRead, .regRvalid, .txEnd, .rxError, .collisionDetect, .frameEnd,
  .fifoReady, .fifoValid, .fifoData, .fifoReset, .rxCompleteIrq, .rxStop,
  .rxIgnore, .baudSelect, .baudValid, .collisionLevel, .collisionEnable);

/* testbench/rfrx_tag_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module rfrx_tag_model (
  input wire clk,
  input wire byteReady,
  output reg byteValid,
  output reg [7:0] byteData,
  output reg bytePartial,
  output reg stuck
);
  integer k; // Wait bound counter
  initial begin
    byteValid = 1'b0;
    byteData = 8'h00;
    bytePartial = 1'b0;
    stuck = 1'b0;
  end
  // Offers one byte and holds it until the receiver takes it
  task send(input logic [7:0] d, input logic p);
    @(negedge clk);
    byteValid = 1'b1;
    byteData = d;
    bytePartial = p;
    k = 0;
    while (!byteReady && k < 200) begin
      k = k + 1;
      @(negedge clk);
    end
    if (k == 200) stuck = 1'b1;
    @(negedge clk);
    byteValid = 1'b0;
    byteData = ~d; // Released line shows no stale byte
  endtask
endmodule // rfrx_tag_model

/* testbench/rfrx_config_regs_tb.sv */
`timescale 1ns/1ps
`include "rfrx_consts.vh"
////////////////////////////////////////////////////////////////////////
module rfrx_config_regs_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] regAddr = 8'h00;
  reg [7:0] regWdata = 8'h00;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg [4:0] ev = 5'h00; // Event pulses
  reg subcarrierLive = 1'b0;
  reg [7:0] errorRegValue = 8'h5a;
  reg crcEnable = 1'b0;
  reg [11:0] dataBitHalfPeriod = 12'h005;
  reg fifoReady = 1'b0;
  wire [7:0] regRdata, byteData, fifoData;
  wire regRvalid, byteValid, bytePartial, byteReady, fifoValid, fifoReset;
  wire frameStartInterrupt, rxCompleteIrq, rxStop, rxIgnore, stuck;
  wire baudValid, singleInputMode, lowPowerCardDetection, collisionEnable;
  wire [1:0] baudSelect, signalSourceSelect, collisionLevel;
  wire [3:0] decoderMinLevel, phaseDetectorMinLevel;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer i;
  integer k;
  always #12.5 clk = ~clk; // 40 MHz
  rfrx_config_regs i_rfrx_config_regs (.clk, .rst_n, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .regRvalid, .txEnd(ev[4]),
    .sofDetect(ev[3]), .subcarrierLive, .collisionDetect(ev[2]),
    .rxError(ev[1]), .errorRegValue, .frameEnd(ev[0]), .crcEnable,
    .dataBitHalfPeriod, .byteValid, .byteData, .bytePartial, .byteReady,
    .fifoValid, .fifoData, .fifoReady, .fifoReset, .frameStartInterrupt,
    .rxCompleteIrq, .rxStop, .rxIgnore, .baudSelect, .baudValid,
    .decoderMinLevel, .phaseDetectorMinLevel, .singleInputMode,
    .lowPowerCardDetection, .signalSourceSelect, .collisionLevel,
    .collisionEnable);
  rfrx_tag_model i_rfrx_tag_model (.clk, .byteReady, .byteValid, .byteData,
    .bytePartial, .stuck);
  ////////////////////////////////////////////////////////////////////////
  // Compares and counts
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask
  // Reads and compares, answer one cycle later
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    chk({7'h00, regRvalid}, 8'h01);
    chk(regRdata, e);
  endtask
  task pulse(input logic [4:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 5'h00;
  endtask
  // Takes one word from the buffer
  task pop(input logic [7:0] e);
    @(negedge clk);
    chk({7'h00, fifoValid}, 8'h01);
    chk(fifoData, e);
    fifoReady = 1'b1;
    @(negedge clk);
    fifoReady = 1'b0;
  endtask
  // Length of the dead time in cycles
  task dead(input logic [7:0] v, input logic [7:0] e);
    wr(`RFRX_OFS_DEAD, v);
    pulse(5'h10);
    k = 0;
    while (rxIgnore && k < 250) begin
      k = k + 1;
      @(negedge clk);
    end
    chk(k[7:0], e);
  endtask
  task close_out;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    for (i = 8'h34; i < 8'h3a; i = i + 1) rd(i[7:0], 8'h00);
    wr(8'h34, 8'hff);
    rd(8'h34, 8'h24);
    wr(8'h35, 8'hff);
    rd(8'h35, 8'hcf);
    wr(8'h38, 8'hd2);
    rd(8'h38, 8'hd2);
    chk({singleInputMode, lowPowerCardDetection,
      signalSourceSelect}, 8'h0d);
    wr(8'h37, 8'ha5);
    chk({decoderMinLevel, phaseDetectorMinLevel}, 8'ha5);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h35, i[7:0]);
      chk({baudValid, baudSelect}, {i == 2 || i == 3, i[1:0]});
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h38, i[7:0]);
      chk({collisionEnable, collisionLevel}, {i != 3, i[1:0]});
    end
    wr(8'h38, 8'h00);
    wr(8'h34, 8'h20);
    pulse(5'h08);
    rd(8'h34, 8'h30);
    chk(frameStartInterrupt, 8'h01);
    wr(8'h34, 8'h20);
    chk(frameStartInterrupt, 8'h00);
    wr(8'h34, 8'h04);
    subcarrierLive = 1'b1;
    rd(8'h34, 8'h07);
    chk(frameStartInterrupt, 8'h01);
    subcarrierLive = 1'b0;
    rd(8'h34, 8'h06);
    wr(8'h34, 8'h04);
    rd(8'h34, 8'h04);
    dead(8'h02, 2 * `RFRX_DT_CARRIER_CYC);
    dead(8'h83, 8'h0f);
    wr(8'h35, 8'h00);
    fork
      begin
        i_rfrx_tag_model.send(8'h11, 1'b0);
        i_rfrx_tag_model.send(8'h22, 1'b0);
        i_rfrx_tag_model.send(8'h33, 1'b0);
      end
      begin
        repeat (8) @(negedge clk);
        chk(byteReady, 8'h00);
        pop(8'h11);
        pop(8'h22);
        pop(8'h33);
      end
    join
    wr(8'h35, 8'h40);
    pulse(5'h01);
    chk({rxStop, rxCompleteIrq}, 8'h01);
    pop(8'h5a);
    wr(8'h35, 8'h00);
    pulse(5'h01);
    chk(rxStop, 8'h01);
    wr(8'h35, 8'h08);
    for (i = 1; i < 3; i = i + 1) begin
      pulse(5'h08);
      i_rfrx_tag_model.send(8'h44, 1'b0);
      pulse(5'h01 << (3 - i));
      chk(fifoReset, 8'h01);
      @(negedge clk);
      chk(fifoValid, 8'h00);
      pulse(5'h01);
      chk(rxCompleteIrq, 8'h00);
    end
    // Collision off, one byte frame: kept, no completion
    wr(8'h38, 8'h03);
    pulse(5'h08);
    i_rfrx_tag_model.send(8'h77, 1'b0);
    pulse(5'h04);
    chk(fifoReset, 8'h00);
    pulse(5'h01);
    chk(rxCompleteIrq, 8'h00);
    pop(8'h77);
    wr(8'h38, 8'h00);
    // Three byte frame under suppression completes normally
    pulse(5'h08);
    i_rfrx_tag_model.send(8'h81, 1'b0);
    i_rfrx_tag_model.send(8'h82, 1'b0);
    pop(8'h81);
    i_rfrx_tag_model.send(8'h83, 1'b0);
    pulse(5'h01);
    chk(rxCompleteIrq, 8'h01);
    pop(8'h82);
    pop(8'h83);
    crcEnable = 1'b1;
    wr(8'h35, 8'h00);
    i_rfrx_tag_model.send(8'h55, 1'b1);
    repeat (3) @(negedge clk);
    chk(fifoValid, 8'h00);
    wr(8'h35, 8'h80);
    i_rfrx_tag_model.send(8'h66, 1'b1);
    pop(8'h66);
    chk(stuck, 8'h00);
    close_out;
  end
endmodule // rfrx_config_regs_tb
